/* rtl/fidq_cfg.svh */
// Purpose: Offsets, field positions, command codes and timing counts for the flash query/guard controller.
// Assumes: 100 MHz mclk, word-mode flash bus.
// Notes:   Counts derive from times in ns; least times round up.
`ifndef FIDQ_CFG_SVH
`define FIDQ_CFG_SVH

// Register byte offsets (low address byte)
`define FIDQ_OFS_CTRL   8'h00
`define FIDQ_OFS_ADDR   8'h04
`define FIDQ_OFS_WDATA  8'h08
`define FIDQ_OFS_STAT   8'h0c
`define FIDQ_OFS_RDATA  8'h10

// Control fields
`define FIDQ_CTRL_GO      0
`define FIDQ_CTRL_OP_LSB  1
`define FIDQ_CTRL_OP_MSB  3
`define FIDQ_CTRL_ERASE   4
`define FIDQ_CTRL_HV      5

// Status fields
`define FIDQ_STAT_BUSY    0
`define FIDQ_STAT_DONE    1
`define FIDQ_STAT_FAIL    2
`define FIDQ_STAT_REFUSED 3
`define FIDQ_STAT_QUERY   4
`define FIDQ_STAT_TMO     5
`define FIDQ_STAT_RDY     6

// Flash command cycles
`define FIDQ_UNLOCK1_ADDR 12'h555
`define FIDQ_UNLOCK1_DATA 16'h00aa
`define FIDQ_UNLOCK2_ADDR 12'h2aa
`define FIDQ_UNLOCK2_DATA 16'h0055
`define FIDQ_QUERY_DATA   16'h0090
`define FIDQ_RESET_DATA   16'h00f0
`define FIDQ_POLL_OK_PROG  8'h00
`define FIDQ_POLL_OK_ERASE 8'h01
`define FIDQ_TOGGLE_BIT   6
`define FIDQ_TMOFAIL_BIT  5

// Timing
`define FIDQ_CLK_NS       10
`define FIDQ_SETUP_NS     20
`define FIDQ_STROBE_NS    120
`define FIDQ_RECOVER_NS   30
`define FIDQ_HWRST_NS     500
`define FIDQ_HWREADY_NS   1000
`define FIDQ_SYNC_CYC     4
`define FIDQ_SETUP_CYC    ((`FIDQ_SETUP_NS + `FIDQ_CLK_NS - 1) / `FIDQ_CLK_NS)
`define FIDQ_STROBE_CYC   ((`FIDQ_STROBE_NS + `FIDQ_CLK_NS - 1) / `FIDQ_CLK_NS)
`define FIDQ_RECOVER_CYC  ((`FIDQ_RECOVER_NS + `FIDQ_CLK_NS - 1) / `FIDQ_CLK_NS)
`define FIDQ_HWRST_CYC    ((`FIDQ_HWRST_NS + `FIDQ_CLK_NS - 1) / `FIDQ_CLK_NS)
`define FIDQ_HWREADY_CYC  ((`FIDQ_HWREADY_NS + `FIDQ_CLK_NS - 1) / `FIDQ_CLK_NS)
`define FIDQ_POLL_MAX     4096
`define FIDQ_LOCKREG_W    16

`endif

/* rtl/fidq_pkg.sv */
// Purpose: Types for the flash query/guard controller.
// Assumes: Constants live in fidq_cfg.svh.
// Notes:   One-hot state codes.
package fidq_pkg;
  typedef enum logic [5:0] {
    ST_IDLE    = 6'b000001,
    ST_LAUNCH  = 6'b000010,
    ST_SETUP   = 6'b000100,
    ST_STROBE  = 6'b001000,
    ST_RECOVER = 6'b010000,
    ST_HWRST   = 6'b100000
  } fidq_state_t;

  typedef enum logic [2:0] {
    OP_READ  = 3'h0,
    OP_WRITE = 3'h1,
    OP_QUERY = 3'h2,
    OP_RESET = 3'h3,
    OP_POLL  = 3'h4,
    OP_HWRST = 3'h5
  } fidq_op_t;
endpackage

/* rtl/fidq_sync3.sv */
// Purpose: Three-flop synchroniser for pin inputs.
// Assumes: Inputs asynchronous to mclk.
// Notes:   Output follows once the second and third stages agree.
`timescale 1ns/1ps
module fidq_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // Data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      syncOut <= '0;
    end else begin
      s1_q <= asyncIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          syncOut[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

/* rtl/fidq_timer.sv */
// Purpose: Phase timer producing a one-cycle expiry pulse.
// Assumes: Load value of at least one.
// Notes:   Expiry comes loadValue edges after the load edge.
`timescale 1ns/1ps
module fidq_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] loadValue,
  output logic              expired
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_q   <= '0;
      expired <= 1'b0;
    end else if (load) begin
      cnt_q   <= loadValue;
      expired <= 1'b0;
    end else begin
      expired <= (cnt_q == W'(1));
      if (cnt_q != '0) begin
        cnt_q <= cnt_q - W'(1);
      end
    end
  end
endmodule

/* rtl/fidq_ctrl.sv */
// Purpose: Host controller driving a parallel NOR flash for ID query, reset and guard-bit status polling.
// Assumes: AHB-Lite zero-wait slave; flash in word mode; pins synchronised through three flops.
// Notes:   Software starts one operation at a time through the control register.
`timescale 1ns/1ps
`include "fidq_cfg.svh"

// Summary of operation
// - Query entry is two unlock writes then the query code, from read-like modes.
// - After a timeout failure the host issues the reset command.
// - Poll toggle bit until steady, then expect 00h program or 01h erase.
// - Host sets freeze to zero after configuring the guard bits; this controller has no guard-bit or freeze register access.
module fidq_ctrl #(
  parameter int ADDR_W   = 26,
  parameter int POLL_MAX = `FIDQ_POLL_MAX
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  // Flash bus
  output logic      [ADDR_W-1:0] flashAddr,
  output logic      [15:0]       flashDqOut,
  output logic                   flashDqOutEnN,
  input  wire logic [15:0]       flashDqIn,
  output logic                   flashCeN,
  output logic                   flashOeN,
  output logic                   flashWeN,
  output logic                   flashResetN,
  output logic                   flashHvA9,
  input  wire logic              flashReadyBusy
);
  localparam int PCW = $clog2(POLL_MAX + 1);

  logic [15:0]          dqSync;
  logic                 rdySync;
  logic                 timerLoad_q;
  logic [15:0]          timerValue_q;
  logic                 timerExpired;

  logic                 ahbWr_q;
  logic [7:0]           ahbAddr_q;
  fidq_pkg::fidq_op_t   ctrlOp_q;
  logic                 ctrlErase_q;
  logic [ADDR_W-1:0]    userAddr_q;
  logic [15:0]          userData_q;
  logic                 done_q;
  logic                 fail_q;
  logic                 refused_q;
  logic                 tmo_q;

  fidq_pkg::fidq_state_t state_q;
  fidq_pkg::fidq_op_t   curOp_q;
  logic [1:0]           step_q;
  logic [PCW-1:0]       pollCnt_q;
  logic                 prevToggle_q;
  logic                 cmdQuery_q;
  logic [15:0]          rdata_q;
  logic                 evtDone_q;
  logic                 evtFail_q;
  logic                 evtRefused_q;
  logic                 evtTmo_q;

  logic                 addrPhase;
  logic                 wrCtrl;
  logic                 wrStat;
  logic                 goPulse;
  logic                 busy;
  logic                 queryActive;
  logic [31:0]          statusWord;

  fidq_sync3 #(.W(17)) uSync (
    .mclk    (mclk),
    .reset   (reset),
    .asyncIn ({flashReadyBusy, flashDqIn}),
    .syncOut ({rdySync, dqSync})
  );

  fidq_timer #(.W(16)) uTimer (
    .mclk      (mclk),
    .reset     (reset),
    .load      (timerLoad_q),
    .loadValue (timerValue_q),
    .expired   (timerExpired)
  );

  // Command sequence tables
  function automatic logic [1:0] seqLast(input fidq_pkg::fidq_op_t op);
    seqLast = (op == fidq_pkg::OP_QUERY) ? 2'd2 : 2'd0;
  endfunction

  function automatic logic seqIsWrite(input fidq_pkg::fidq_op_t op);
    seqIsWrite = (op == fidq_pkg::OP_WRITE) || (op == fidq_pkg::OP_QUERY) || (op == fidq_pkg::OP_RESET);
  endfunction

  function automatic logic [ADDR_W-1:0] seqAddr(input fidq_pkg::fidq_op_t op, input logic [1:0] step,
                                                input logic [ADDR_W-1:0] ua);
    seqAddr = ua;
    if (op == fidq_pkg::OP_QUERY) begin
      seqAddr = ADDR_W'((step == 2'd1) ? `FIDQ_UNLOCK2_ADDR : `FIDQ_UNLOCK1_ADDR);
    end else if (op == fidq_pkg::OP_RESET) begin
      seqAddr = '0;
    end
  endfunction

  function automatic logic [15:0] seqData(input fidq_pkg::fidq_op_t op, input logic [1:0] step,
                                          input logic [15:0] ud);
    seqData = ud;
    if (op == fidq_pkg::OP_QUERY) begin
      case (step)
        2'd0:    seqData = `FIDQ_UNLOCK1_DATA;
        2'd1:    seqData = `FIDQ_UNLOCK2_DATA;
        default: seqData = `FIDQ_QUERY_DATA;
      endcase
    end else if (op == fidq_pkg::OP_RESET) begin
      seqData = `FIDQ_RESET_DATA;
    end
  endfunction

  assign busy        = (state_q != fidq_pkg::ST_IDLE);
  assign queryActive = cmdQuery_q | flashHvA9;
  assign statusWord  = {25'h0, rdySync, tmo_q, queryActive, refused_q, fail_q, done_q, busy};

  // AHB-Lite slave
  assign addrPhase = hsel && hready && htrans[1];
  assign wrCtrl    = ahbWr_q && (ahbAddr_q == `FIDQ_OFS_CTRL);
  assign wrStat    = ahbWr_q && (ahbAddr_q == `FIDQ_OFS_STAT);
  assign goPulse   = wrCtrl && hwdata[`FIDQ_CTRL_GO];

  always_ff @(posedge mclk) begin
    if (reset) begin
      ahbWr_q   <= 1'b0;
      ahbAddr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
    end else begin
      ahbWr_q   <= addrPhase && hwrite;
      ahbAddr_q <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addrPhase && !hwrite) begin
        case (haddr[7:0])
          `FIDQ_OFS_CTRL:  hrdata <= {26'h0, flashHvA9, ctrlErase_q, ctrlOp_q, 1'b0};
          `FIDQ_OFS_ADDR:  hrdata <= 32'(userAddr_q);
          `FIDQ_OFS_WDATA: hrdata <= {16'h0, userData_q};
          `FIDQ_OFS_STAT:  hrdata <= statusWord;
          `FIDQ_OFS_RDATA: hrdata <= {16'h0, rdata_q};
          default:         hrdata <= 32'h0;
        endcase
      end
    end
  end

  // Software-written settings, held while an operation runs
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrlOp_q    <= fidq_pkg::OP_READ;
      ctrlErase_q <= 1'b0;
      flashHvA9   <= 1'b0;
      userAddr_q  <= '0;
      userData_q  <= 16'h0;
    end else if (!busy) begin
      if (wrCtrl) begin
        ctrlOp_q    <= fidq_pkg::fidq_op_t'(hwdata[`FIDQ_CTRL_OP_MSB:`FIDQ_CTRL_OP_LSB]);
        ctrlErase_q <= hwdata[`FIDQ_CTRL_ERASE];
        flashHvA9   <= hwdata[`FIDQ_CTRL_HV];
      end
      if (ahbWr_q && (ahbAddr_q == `FIDQ_OFS_ADDR)) begin
        userAddr_q <= hwdata[ADDR_W-1:0];
      end
      if (ahbWr_q && (ahbAddr_q == `FIDQ_OFS_WDATA)) begin
        userData_q <= hwdata[15:0];
      end
    end
  end

  // Sticky status; a new event wins over a write-one clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      done_q    <= 1'b0;
      fail_q    <= 1'b0;
      refused_q <= 1'b0;
      tmo_q     <= 1'b0;
    end else begin
      done_q    <= evtDone_q    | (done_q    & ~(wrStat & hwdata[`FIDQ_STAT_DONE]));
      fail_q    <= evtFail_q    | (fail_q    & ~(wrStat & hwdata[`FIDQ_STAT_FAIL]));
      refused_q <= evtRefused_q | (refused_q & ~(wrStat & hwdata[`FIDQ_STAT_REFUSED]));
      tmo_q     <= evtTmo_q     | (tmo_q     & ~(wrStat & hwdata[`FIDQ_STAT_TMO]));
    end
  end

  // Flash bus sequencer
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q       <= fidq_pkg::ST_IDLE;
      curOp_q       <= fidq_pkg::OP_READ;
      step_q        <= 2'd0;
      pollCnt_q     <= '0;
      prevToggle_q  <= 1'b0;
      cmdQuery_q    <= 1'b0;
      rdata_q       <= 16'h0;
      timerLoad_q   <= 1'b0;
      timerValue_q  <= 16'h0;
      evtDone_q     <= 1'b0;
      evtFail_q     <= 1'b0;
      evtRefused_q  <= 1'b0;
      evtTmo_q      <= 1'b0;
      flashAddr     <= '0;
      flashDqOut    <= 16'h0;
      flashDqOutEnN <= 1'b1;
      flashCeN      <= 1'b1;
      flashOeN      <= 1'b1;
      flashWeN      <= 1'b1;
      flashResetN   <= 1'b1;
    end else begin
      timerLoad_q  <= 1'b0;
      evtDone_q    <= 1'b0;
      evtFail_q    <= 1'b0;
      evtRefused_q <= 1'b0;
      evtTmo_q     <= 1'b0;
      if (goPulse && busy) begin
        evtRefused_q <= 1'b1;
      end
      case (state_q)
        fidq_pkg::ST_IDLE: begin
          if (goPulse) begin
            curOp_q   <= ctrlOp_q;
            step_q    <= 2'd0;
            pollCnt_q <= '0;
            if (queryActive && (ctrlOp_q != fidq_pkg::OP_READ) && (ctrlOp_q != fidq_pkg::OP_RESET)
                && (ctrlOp_q != fidq_pkg::OP_HWRST)) begin
              evtRefused_q <= 1'b1;
            end else if (ctrlOp_q == fidq_pkg::OP_HWRST) begin
              flashResetN  <= 1'b0;
              timerLoad_q  <= 1'b1;
              timerValue_q <= 16'(`FIDQ_HWRST_CYC);
              state_q      <= fidq_pkg::ST_HWRST;
            end else begin
              state_q <= fidq_pkg::ST_LAUNCH;
            end
          end
        end
        fidq_pkg::ST_LAUNCH: begin
          flashAddr    <= seqAddr(curOp_q, step_q, userAddr_q);
          flashDqOut   <= seqData(curOp_q, step_q, userData_q);
          flashDqOutEnN <= ~seqIsWrite(curOp_q);
          flashCeN     <= 1'b0;
          timerLoad_q  <= 1'b1;
          timerValue_q <= 16'(`FIDQ_SETUP_CYC);
          state_q      <= fidq_pkg::ST_SETUP;
        end
        fidq_pkg::ST_SETUP: begin
          if (timerExpired) begin
            flashWeN     <= ~seqIsWrite(curOp_q);
            flashOeN     <= seqIsWrite(curOp_q);
            timerLoad_q  <= 1'b1;
            timerValue_q <= seqIsWrite(curOp_q) ? 16'(`FIDQ_STROBE_CYC)
                                                : 16'(`FIDQ_STROBE_CYC + `FIDQ_SYNC_CYC);
            state_q      <= fidq_pkg::ST_STROBE;
          end
        end
        fidq_pkg::ST_STROBE: begin
          if (timerExpired) begin
            if (!seqIsWrite(curOp_q)) begin
              rdata_q <= dqSync;
            end
            flashWeN     <= 1'b1;
            flashOeN     <= 1'b1;
            flashCeN     <= 1'b1;
            timerLoad_q  <= 1'b1;
            timerValue_q <= 16'(`FIDQ_RECOVER_CYC);
            state_q      <= fidq_pkg::ST_RECOVER;
          end
        end
        fidq_pkg::ST_RECOVER: begin
          if (timerExpired) begin
            flashDqOutEnN <= 1'b1;
            if (step_q != seqLast(curOp_q)) begin
              step_q  <= step_q + 2'd1;
              state_q <= fidq_pkg::ST_LAUNCH;
            end else if (curOp_q == fidq_pkg::OP_POLL) begin
              pollCnt_q    <= pollCnt_q + PCW'(1);
              prevToggle_q <= rdata_q[`FIDQ_TOGGLE_BIT];
              if ((pollCnt_q != '0) && (rdata_q[`FIDQ_TOGGLE_BIT] == prevToggle_q)) begin
                evtFail_q <= (rdata_q[7:0] != (ctrlErase_q ? `FIDQ_POLL_OK_ERASE : `FIDQ_POLL_OK_PROG));
                evtDone_q <= 1'b1;
                state_q   <= fidq_pkg::ST_IDLE;
              end else if ((pollCnt_q != '0) && rdata_q[`FIDQ_TMOFAIL_BIT]) begin
                evtTmo_q  <= 1'b1;
                evtFail_q <= 1'b1;
                curOp_q   <= fidq_pkg::OP_RESET;
                step_q    <= 2'd0;
                state_q   <= fidq_pkg::ST_LAUNCH;
              end else if (pollCnt_q == PCW'(POLL_MAX - 1)) begin
                evtFail_q <= 1'b1;
                evtDone_q <= 1'b1;
                state_q   <= fidq_pkg::ST_IDLE;
              end else begin
                state_q <= fidq_pkg::ST_LAUNCH;
              end
            end else begin
              if (curOp_q == fidq_pkg::OP_QUERY) begin
                cmdQuery_q <= 1'b1;
              end else if (curOp_q == fidq_pkg::OP_RESET) begin
                cmdQuery_q <= 1'b0;
              end
              evtDone_q <= 1'b1;
              state_q   <= fidq_pkg::ST_IDLE;
            end
          end
        end
        fidq_pkg::ST_HWRST: begin
          if (timerExpired) begin
            if (step_q == 2'd0) begin
              flashResetN  <= 1'b1;
              cmdQuery_q   <= 1'b0;
              step_q       <= 2'd1;
              timerLoad_q  <= 1'b1;
              timerValue_q <= 16'(`FIDQ_HWREADY_CYC);
            end else begin
              evtDone_q <= 1'b1;
              state_q   <= fidq_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= fidq_pkg::ST_IDLE;
        end
      endcase
    end
  end
endmodule

/* verification/fidq_ctrl_sva.sv */
// Purpose: Port checks on the flash query controller.
// Assumes: Default strobe timing at 100 MHz.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ps
module fidq_ctrl_sva (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // Observed ports
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [15:0] flashDqOut,
  input wire logic        flashDqOutEnN,
  input wire logic        flashCeN,
  input wire logic        flashOeN,
  input wire logic        flashWeN,
  input wire logic        flashResetN
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_ans; hreadyout && !hresp; endproperty
  a_ans: assert property (p_ans) else $error("bus answer not ready or okay");
  property p_wesel; !flashWeN |-> !flashCeN && flashOeN && !flashDqOutEnN; endproperty
  a_wesel: assert property (p_wesel) else $error("write strobe without select or data");
  property p_wesetup; $fell(flashWeN) |-> $past(flashCeN, 2) == 1'b0; endproperty
  a_wesetup: assert property (p_wesetup) else $error("write strobe setup too short");
  property p_wewid; $fell(flashWeN) |-> !flashWeN [*8] ##1 !flashWeN [*6] ##1 flashWeN; endproperty
  a_wewid: assert property (p_wewid) else $error("write strobe width wrong");
  property p_hold; !flashWeN && !$fell(flashWeN) |-> $stable(flashDqOut); endproperty
  a_hold: assert property (p_hold) else $error("write data moved in strobe");
  property p_oewid; $fell(flashOeN) |-> ##17 !flashOeN ##1 flashOeN; endproperty
  a_oewid: assert property (p_oewid) else $error("read strobe width wrong");
  property p_nofight; !flashOeN |-> flashDqOutEnN; endproperty
  a_nofight: assert property (p_nofight) else $error("data driven during read");
  property p_rst; $fell(flashResetN) |-> ##51 !flashResetN ##1 flashResetN; endproperty
  a_rst: assert property (p_rst) else $error("hardware reset pulse width wrong");
  property p_rstq; !flashResetN |-> flashCeN && flashWeN && flashOeN; endproperty
  a_rstq: assert property (p_rstq) else $error("strobe during hardware reset");
endmodule

/* verification/fidq_flash_model.sv */
// Purpose: Behavioural flash device for query, reset and status reads.
// Assumes: Word mode; pins sampled on mclk.
// Notes:   A released data bus shows the inverse of its last value.
`timescale 1ns/1ps
module fidq_flash_model #(
  parameter logic [7:0] MAKER = 8'h3c, // Arbitrary value
  parameter logic [7:0] DEVID = 8'h7e  // Arbitrary value
) (
  // Clock
  input  wire logic        mclk,
  // Flash pins
  input  wire logic [25:0] fAddr,
  input  wire logic [15:0] fDqOut,
  input  wire logic        fCeN,
  input  wire logic        fOeN,
  input  wire logic        fWeN,
  input  wire logic        fResetN,
  input  wire logic        fHvA9,
  output logic      [15:0] fDq,
  output logic             fRdyBsy,
  // Test control
  input  wire logic        loadBusy,
  input  wire logic [7:0]  busyCnt,
  input  wire logic        failIn,
  input  wire logic [7:0]  pollVal
);
  logic [1:0]  cyc = 2'h0;
  logic        queryMode = 1'b0;
  logic        failQ = 1'b0;
  logic        tgl = 1'b0;
  logic        weQ = 1'b1;
  logic        oeQ = 1'b1;
  logic        ceQ = 1'b1;
  logic        freeze = 1'b1;
  logic [7:0]  busyLeft = 8'h0;
  logic [3:0]  volGuard = 4'hf;
  logic [3:0]  override = 4'hf;
  logic [15:0] rdVal;
  logic [15:0] lastQ = 16'h0;
  always_comb begin
    if (busyLeft != 8'h0) rdVal = {9'h0, tgl, failQ, 5'h0};
    else if (queryMode || fHvA9) begin
      case (fAddr[1:0])
        2'h0: rdVal = {8'h0, MAKER};
        2'h1: rdVal = {8'h0, DEVID};
        2'h2: rdVal = {15'h0, ~volGuard[fAddr[17:16]]};
        default: rdVal = 16'h0;
      endcase
    end else rdVal = {fAddr[7:0], pollVal};
    fDq = (!fCeN && !fOeN) ? rdVal : ~lastQ;
  end
  assign fRdyBsy = (busyLeft == 8'h0);
  always @(posedge mclk) begin
    weQ <= fWeN;
    oeQ <= fOeN;
    ceQ <= fCeN;
    if (!fCeN && !fOeN) lastQ <= rdVal;
    if (!fResetN) begin
      cyc <= 2'h0;
      queryMode <= 1'b0;
      busyLeft <= 8'h0;
      failQ <= 1'b0;
      volGuard <= 4'hf;
      override <= 4'hf;
      freeze <= 1'b1;
    end else if (loadBusy) begin
      busyLeft <= busyCnt;
      failQ <= failIn;
    end else if (fWeN && !weQ && !ceQ) begin
      if (fDqOut[7:0] == 8'hf0) begin
        if (busyLeft == 8'h0 || failQ) begin
          queryMode <= 1'b0;
          busyLeft <= 8'h0;
          failQ <= 1'b0;
          cyc <= 2'h0;
        end
      end else if (!queryMode) begin
        case (cyc)
          2'h0: cyc <= ({fAddr[11:0], fDqOut} == 28'h55500aa) ? 2'h1 : 2'h0;
          2'h1: cyc <= ({fAddr[11:0], fDqOut} == 28'h2aa0055) ? 2'h2 : 2'h0;
          default: begin
            queryMode <= ({fAddr[11:0], fDqOut} == 28'h5550090);
            cyc <= 2'h0;
          end
        endcase
      end
    end else if (fOeN && !oeQ && !ceQ && busyLeft != 8'h0) begin
      busyLeft <= busyLeft - 8'h1;
      tgl <= ~tgl;
    end
  end
endmodule

/* verification/fidq_ctrl_test.sv */
// Purpose: Self-checking bench for the flash query controller.
// Assumes: Poll limit shortened to 8 reads.
// Notes:   Each scenario is one task.
`timescale 1ns/1ps
`include "fidq_cfg.svh"
module fidq_ctrl_test;
  localparam logic [7:0] MKR = 8'h3c;
  // Clock, reset and bus
  logic        mclk, reset, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, v, st;
  // Flash pins and model control
  logic [25:0] fAddr;
  logic [15:0] fDqOut, fDqIn, mdlDq;
  logic        fDqEnN, fCeN, fOeN, fWeN, fRstN, fHv, fRdy, loadBusy, failIn;
  logic [7:0]  busyCnt, pollVal;
  int          error_cnt, num_checks;
  assign fDqIn = fDqEnN ? mdlDq : fDqOut;
  fidq_ctrl #(.POLL_MAX(8)) i_dut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .flashAddr(fAddr), .flashDqOut(fDqOut), .flashDqOutEnN(fDqEnN), .flashDqIn(fDqIn),
    .flashCeN(fCeN), .flashOeN(fOeN), .flashWeN(fWeN), .flashResetN(fRstN), .flashHvA9(fHv),
    .flashReadyBusy(fRdy));
  fidq_flash_model #(.MAKER(MKR)) i_flash (.mclk(mclk), .fAddr(fAddr), .fDqOut(fDqOut), .fCeN(fCeN),
    .fOeN(fOeN), .fWeN(fWeN), .fResetN(fRstN), .fHvA9(fHv), .fDq(mdlDq), .fRdyBsy(fRdy),
    .loadBusy(loadBusy), .busyCnt(busyCnt), .failIn(failIn), .pollVal(pollVal));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic waitRdy;
    int n;
    n = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        error_cnt++;
        conclude();
      end
      @(posedge mclk);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    waitRdy();
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic runOp(input logic [25:0] fa, input logic [2:0] op, input logic [31:0] ex);
    int n;
    n = 0;
    st = 32'h0;
    wr(`FIDQ_OFS_ADDR, {6'h0, fa});
    wr(`FIDQ_OFS_CTRL, ex | {28'h0, op, 1'b0});
    wr(`FIDQ_OFS_CTRL, ex | {28'h0, op, 1'b1});
    while (st[1] !== 1'b1 && st[3] !== 1'b1) begin
      ahb(1'b0, `FIDQ_OFS_STAT, 32'h0, st);
      n++;
      if (n > 400) begin
        error_cnt++;
        conclude();
      end
    end
    wr(`FIDQ_OFS_STAT, 32'h2e);
    ahb(1'b0, `FIDQ_OFS_RDATA, 32'h0, v);
  endtask
  task automatic loadB(input logic [7:0] c, input logic f);
    busyCnt <= c;
    failIn <= f;
    loadBusy <= 1'b1;
    @(posedge mclk);
    loadBusy <= 1'b0;
  endtask
  task automatic tRegs;
    ahb(1'b0, `FIDQ_OFS_STAT, 32'h0, v);
    chk("status after reset", v, 32'h40);
    wr(8'h20, 32'hffff_ffff);
    ahb(1'b0, 8'h20, 32'h0, v);
    chk("unmapped read", v, 32'h0);
    $display("tRegs finished");
  endtask
  task automatic tQuery;
    logic [25:0] qa[4] = '{26'h0, 26'h1, 26'h30004, 26'h2};
    logic [15:0] qe[4] = '{{8'h0, MKR}, 16'h7e, {8'h0, MKR}, 16'h0};
    runOp(26'h0, fidq_pkg::OP_QUERY, 32'h0);
    chk("query entered", {st[4], i_flash.queryMode}, 2'b11);
    for (int i = 0; i < 4; i++) begin
      runOp(qa[i], fidq_pkg::OP_READ, 32'h0);
      chk("query read", v[15:0], qe[i]);
    end
    runOp(26'h0, fidq_pkg::OP_WRITE, 32'h0);
    chk("write refused", st[3], 1'b1);
    runOp(26'h0, fidq_pkg::OP_RESET, 32'h0);
    chk("query left", {st[4], i_flash.queryMode}, 2'b00);
    runOp(26'h5, fidq_pkg::OP_READ, 32'h0);
    chk("array read", v[15:0], {8'h05, pollVal});
    $display("tQuery finished");
  endtask
  task automatic tHv;
    runOp(26'h0, fidq_pkg::OP_READ, 32'h20);
    chk("voltage pin", fHv, 1'b1);
    chk("voltage query read", v[15:0], {8'h0, MKR});
    runOp(26'h0, fidq_pkg::OP_READ, 32'h0);
    chk("voltage removed read", v[15:0], {8'h0, pollVal});
    $display("tHv finished");
  endtask
  task automatic tPoll;
    logic [8:0] cs[3] = '{9'b0_0000_0000, 9'b1_0000_0001, 9'b1_0000_0000};
    logic       ef[3] = '{1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++) begin
      pollVal <= cs[i][7:0];
      loadB(8'h3, 1'b0);
      runOp(26'h0, fidq_pkg::OP_POLL, {27'h0, cs[i][8], 4'h0});
      chk("poll fail flag", st[2], ef[i]);
    end
    loadB(8'd100, 1'b1);
    runOp(26'h0, fidq_pkg::OP_POLL, 32'h0);
    chk("timeout and fail", {st[5], st[2]}, 2'b11);
    chk("auto reset taken", i_flash.busyLeft, 8'h0);
    loadB(8'd100, 1'b0);
    runOp(26'h0, fidq_pkg::OP_POLL, 32'h0);
    chk("poll limit", {st[5], st[2], i_flash.busyLeft}, {2'b01, 8'd92});
    loadB(8'h5, 1'b0);
    runOp(26'h0, fidq_pkg::OP_RESET, 32'h0);
    chk("reset ignored busy", i_flash.busyLeft, 8'h5);
    chk("busy pin seen", st[6], 1'b0);
    loadB(8'h0, 1'b0);
    $display("tPoll finished");
  endtask
  task automatic tHwrst;
    runOp(26'h0, fidq_pkg::OP_QUERY, 32'h0);
    runOp(26'h0, fidq_pkg::OP_HWRST, 32'h0);
    chk("query after hw reset", {st[4], i_flash.queryMode}, 2'b00);
    chk("volatile defaults", {i_flash.volGuard, i_flash.override}, 8'hff);
    $display("tHwrst finished");
  endtask
  initial begin
    error_cnt = 0;
    num_checks = 0;
    reset = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    loadBusy = 1'b0;
    busyCnt = 8'h0;
    failIn = 1'b0;
    pollVal = 8'h0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (6) @(posedge mclk);
    tRegs();
    tQuery();
    tHv();
    tPoll();
    tHwrst();
    conclude();
  end
endmodule
bind fidq_ctrl fidq_ctrl_sva i_sva (.mclk(mclk), .reset(reset), .hreadyout(hreadyout), .hresp(hresp),
  .flashDqOut(flashDqOut), .flashDqOutEnN(flashDqOutEnN), .flashCeN(flashCeN), .flashOeN(flashOeN),
  .flashWeN(flashWeN), .flashResetN(flashResetN));
